// [hw/gpio_cfg_host.sv]
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module gpio_cfg_host #(
    parameter int SCLK_HALF = gpio_cfg_pkg::SCLK_HALF_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    spi_link_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [5:0] {
        IDLE = 6'h01, LEAD = 6'h02, HIGH = 6'h04, LOW = 6'h08, TRAIL = 6'h10, GAP = 6'h20
    } link_state_t;

    link_state_t state;
    logic [15:0] tx;
    logic [15:0] last_cmd;
    logic [15:0] rx;
    logic [15:0] rx_word;
    logic [15:0] next_cmd;
    logic [15:0] div;
    logic [gpio_cfg_pkg::CNT_W-1:0] bits;
    logic busy;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic miso_a, miso_b, miso_c, miso_f;
    logic half_done;
    logic start;

    // Top bit cleared and reserved bits zeroed before anything is sent.
    always_comb begin
        next_cmd = w_data[15:0];
        next_cmd[gpio_cfg_pkg::TOP_BIT] = 1'b0;
        case (next_cmd[gpio_cfg_pkg::ADDR_MSB:gpio_cfg_pkg::ADDR_LSB])
            gpio_cfg_pkg::ADDR_OUT_EN: next_cmd = next_cmd & ~gpio_cfg_pkg::RSV_OUT_EN;
            gpio_cfg_pkg::ADDR_IN_SEL: next_cmd = next_cmd & ~gpio_cfg_pkg::RSV_IN_SEL;
            default: next_cmd = next_cmd & ~gpio_cfg_pkg::RSV_OTHER;
        endcase
    end

    assign start = aw_held && w_held && !s_axi_bvalid && !busy
        && aw_addr == gpio_cfg_pkg::CMD_OFFSET && w_strb[1:0] == 2'h3;
    assign half_done = div == 16'(SCLK_HALF - 1);

    // Write address and data are taken independently; the answer waits for both.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpio_cfg_pkg::RESP_OKAY;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr == gpio_cfg_pkg::CMD_OFFSET || aw_addr == gpio_cfg_pkg::STATUS_OFFSET
                    || aw_addr == gpio_cfg_pkg::RX_OFFSET) begin
                    s_axi_bresp <= gpio_cfg_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= gpio_cfg_pkg::RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Reads answer one cycle after the address is taken.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= gpio_cfg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= gpio_cfg_pkg::RESP_OKAY;
            case (s_axi_araddr)
                gpio_cfg_pkg::CMD_OFFSET: s_axi_rdata <= {16'h0, last_cmd};
                gpio_cfg_pkg::STATUS_OFFSET: s_axi_rdata <= {31'h0, busy};
                gpio_cfg_pkg::RX_OFFSET: s_axi_rdata <= {16'h0, rx_word};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= gpio_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // The shifter empties as it sends, so the last command is kept apart for readback.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            last_cmd <= 16'h0;
        end else if (state == IDLE && start) begin
            last_cmd <= next_cmd;
        end
    end

    // Returned data is a pin from the far end, so it is filtered before use.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            miso_a <= 1'b0;
            miso_b <= 1'b0;
            miso_c <= 1'b0;
            miso_f <= 1'b0;
        end else begin
            miso_a <= link.miso;
            miso_b <= miso_a;
            miso_c <= miso_b;
            if (miso_b == miso_c) begin
                miso_f <= miso_c;
            end
        end
    end

    // Frame engine: data changes after the rising edge, both ends sample at the falling one.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= IDLE;
            link.sclk <= 1'b1;
            link.sync_n <= 1'b1;
            link.mosi <= 1'b0;
            tx <= 16'h0;
            rx <= 16'h0;
            rx_word <= 16'h0;
            div <= 16'h0;
            bits <= '0;
            busy <= 1'b0;
        end else begin
            div <= half_done ? 16'h0 : div + 16'h1;
            case (state)
                IDLE: begin
                    div <= 16'h0;
                    if (start) begin
                        busy <= 1'b1;
                        tx <= next_cmd;
                        link.sync_n <= 1'b0;
                        link.mosi <= next_cmd[gpio_cfg_pkg::TOP_BIT];
                        bits <= '0;
                        state <= LEAD;
                    end
                end
                LEAD: if (half_done) state <= HIGH;
                HIGH: if (half_done) begin
                    link.sclk <= 1'b0;
                    rx <= {rx[14:0], miso_f};
                    state <= LOW;
                end
                LOW: if (half_done) begin
                    link.sclk <= 1'b1;
                    if (bits == gpio_cfg_pkg::CNT_W'(gpio_cfg_pkg::FRAME_BITS - 1)) begin
                        state <= TRAIL;
                    end else begin
                        bits <= bits + 1'b1;
                        tx <= {tx[14:0], 1'b0};
                        link.mosi <= tx[14];
                        state <= HIGH;
                    end
                end
                TRAIL: if (half_done) begin
                    link.sync_n <= 1'b1;
                    rx_word <= rx;
                    state <= GAP;
                end
                GAP: if (half_done) begin
                    busy <= 1'b0;
                    state <= IDLE;
                end
                default: state <= IDLE;
            endcase
        end
    end
endmodule : gpio_cfg_host
`default_nettype wire

// [hw/gpio_cfg_pkg.sv]
package gpio_cfg_pkg;
    // Frame layout shared by both ends of the serial link.
    localparam int FRAME_BITS = 16;
    localparam int PINS = 8;
    localparam int TOP_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 11;
    localparam int READBACK_BIT = 10;
    localparam int BUSY_EN_BIT = 8;
    localparam int OUT_EN_W = 9;
    localparam int CNT_W = 5;

    // Register addresses carried in the frame.
    localparam logic [3:0] ADDR_OUT_EN = 4'h8;
    localparam logic [3:0] ADDR_OUT_LEVEL = 4'h9;
    localparam logic [3:0] ADDR_IN_SEL = 4'ha;
    localparam logic [3:0] ADDR_OPEN_DRAIN = 4'hc;

    // Reserved bits that the sender forces low, per register.
    localparam logic [15:0] RSV_OUT_EN = 16'h0600;
    localparam logic [15:0] RSV_IN_SEL = 16'h0300;
    localparam logic [15:0] RSV_OTHER = 16'h0700;

    // Reset values of the pin registers.
    localparam logic [8:0] OUT_EN_RESET = 9'h000;
    localparam logic [7:0] PIN_RESET = 8'h00;

    // Controller register map, byte addresses on the AXI4-Lite side.
    localparam int AXI_AW = 4;
    localparam logic [3:0] CMD_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] RX_OFFSET = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Half period of the serial clock in reference clock cycles.
    localparam int SCLK_HALF_CYCLES = 8;
endpackage : gpio_cfg_pkg

// [hw/spi_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
    logic sclk;
    logic sync_n;
    logic mosi;
    logic miso;

    // The controller makes the clock and frame, the pin device answers.
    modport device (
        input sclk,
        input sync_n,
        input mosi,
        output miso
    );
    modport host (
        output sclk,
        output sync_n,
        output mosi,
        input miso
    );
endinterface : spi_link_if
`default_nettype wire

// [hw/gpio_cfg_device.sv]
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Address 1000 writes the output enable register.
// - Bit 8 turns pin seven into busy.
// - Enable bit one makes pin an output.
// - Address 1100 writes the open-drain select.
// - Open-drain bit applies only to output pins.
// - Address 1001 latches the output levels.
// - Level bit one drives high, zero low.
// - Address 1010 selects input select and readback.
// - Readback bit set returns pins next frame.
// - Readback bit clear writes input selection only.
// - Input select bit one makes pin input.
// - Host writes reserved bits as zero.
// - Level bits for non-output pins are ignored.
// - Open-drain pins pull low or float.
// - Unrequested pins read back as zero.
module gpio_cfg_device (
    input wire logic ref_clk,
    input wire logic reset,
    spi_link_if.device link,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    localparam int PINS = gpio_cfg_pkg::PINS;
    localparam int SW = PINS + 3;
    localparam logic [SW-1:0] SYNC_IDLE = {{PINS{1'b0}}, 3'h3};

    // Synchroniser stages: bit 0 clock, bit 1 frame select, bit 2 data, then the pins.
    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    logic [SW-1:0] sync_c;
    logic [SW-1:0] filt;
    logic sclk_q;
    logic sel_q;
    logic sclk_f;
    logic sel_n_f;
    logic mosi_f;
    logic [PINS-1:0] pins_f;
    logic frame_start;
    logic sclk_fall;
    logic commit;

    logic [15:0] rx;
    logic [15:0] tx;
    logic [15:0] next_word;
    logic [15:0] next_tx;
    logic [gpio_cfg_pkg::CNT_W-1:0] bit_cnt;
    logic [3:0] addr;

    logic [gpio_cfg_pkg::OUT_EN_W-1:0] out_en;
    logic [PINS-1:0] level;
    logic [PINS-1:0] in_sel;
    logic [PINS-1:0] open_drain;
    logic [PINS-1:0] rb_mask;
    logic rb_pending;
    logic busy_n;

    // Every input from the link or the pins passes three flops; a change is
    // accepted only when the second and third agree, which rejects one-cycle glitches.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync_a <= SYNC_IDLE;
            sync_b <= SYNC_IDLE;
            sync_c <= SYNC_IDLE;
            filt <= SYNC_IDLE;
        end else begin
            sync_a <= {pin_in, link.mosi, link.sync_n, link.sclk};
            sync_b <= sync_a;
            sync_c <= sync_b;
            filt <= (sync_c & ~(sync_b ^ sync_c)) | (filt & (sync_b ^ sync_c));
        end
    end

    assign sclk_f = filt[0];
    assign sel_n_f = filt[1];
    assign mosi_f = filt[2];
    assign pins_f = filt[SW-1:3];

    // Edge history of the filtered clock and frame select.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclk_q <= 1'b1;
            sel_q <= 1'b1;
        end else begin
            sclk_q <= sclk_f;
            sel_q <= sel_n_f;
        end
    end

    assign frame_start = sel_q && !sel_n_f;
    assign sclk_fall = sclk_q && !sclk_f && !sel_n_f;
    assign commit = sclk_fall && bit_cnt == gpio_cfg_pkg::CNT_W'(gpio_cfg_pkg::FRAME_BITS - 1);
    assign next_word = {rx[14:0], mosi_f};
    assign addr = next_word[gpio_cfg_pkg::ADDR_MSB:gpio_cfg_pkg::ADDR_LSB];
    // Only pins that were both requested and set as inputs are returned.
    assign next_tx = rb_pending ? {8'h00, pins_f & rb_mask} : 16'h0;

    // Receive shifter; bits past the sixteenth of an over-long frame are dropped.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx <= 16'h0;
            bit_cnt <= '0;
        end else if (frame_start) begin
            bit_cnt <= '0;
        end else if (sclk_fall && bit_cnt != gpio_cfg_pkg::CNT_W'(gpio_cfg_pkg::FRAME_BITS)) begin
            rx <= next_word;
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // Transmit shifter moves on the falling edge, so the host has a full
    // clock period to see each bit before it samples on the next fall.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx <= 16'h0;
            link.miso <= 1'b0;
        end else if (frame_start) begin
            tx <= next_tx;
            link.miso <= next_tx[gpio_cfg_pkg::TOP_BIT];
        end else if (sel_n_f) begin
            link.miso <= 1'b0;
        end else if (sclk_fall) begin
            tx <= {tx[14:0], 1'b0};
            link.miso <= tx[14];
        end
    end

    // Busy is shown low from the start of a frame until its word is applied.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy_n <= 1'b1;
        end else if (frame_start) begin
            busy_n <= 1'b0;
        end else if (commit || sel_n_f) begin
            busy_n <= 1'b1;
        end
    end

    // Register writes; frames with the top bit set belong to other functions and are ignored.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            out_en <= gpio_cfg_pkg::OUT_EN_RESET;
            level <= gpio_cfg_pkg::PIN_RESET;
            in_sel <= gpio_cfg_pkg::PIN_RESET;
            open_drain <= gpio_cfg_pkg::PIN_RESET;
        end else if (commit && !next_word[gpio_cfg_pkg::TOP_BIT]) begin
            case (addr)
                gpio_cfg_pkg::ADDR_OUT_EN: begin
                    out_en <= next_word[gpio_cfg_pkg::OUT_EN_W-1:0];
                end
                gpio_cfg_pkg::ADDR_OUT_LEVEL: begin
                    level <= (next_word[7:0] & out_en[7:0]) | (level & ~out_en[7:0]);
                end
                gpio_cfg_pkg::ADDR_IN_SEL: begin
                    if (!next_word[gpio_cfg_pkg::READBACK_BIT]) begin
                        in_sel <= next_word[7:0];
                    end
                end
                gpio_cfg_pkg::ADDR_OPEN_DRAIN: begin
                    open_drain <= next_word[7:0];
                end
                default: begin
                    out_en <= out_en;
                end
            endcase
        end
    end

    // Readback request: armed by a frame, consumed by the start of the next one.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rb_pending <= 1'b0;
            rb_mask <= gpio_cfg_pkg::PIN_RESET;
        end else if (commit && !next_word[gpio_cfg_pkg::TOP_BIT]
            && addr == gpio_cfg_pkg::ADDR_IN_SEL && next_word[gpio_cfg_pkg::READBACK_BIT]) begin
            rb_pending <= 1'b1;
            rb_mask <= next_word[7:0] & in_sel;
        end else if (frame_start) begin
            rb_pending <= 1'b0;
        end
    end

    // Pin drivers, one per pin.
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            logic drive_level;
            // Pin seven shows busy instead of its level when that option is on.
            if (i == PINS - 1) begin : g_busy
                assign drive_level = out_en[gpio_cfg_pkg::BUSY_EN_BIT] ? busy_n : level[i];
            end else begin : g_plain
                assign drive_level = level[i];
            end
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    pin_out[i] <= 1'b0;
                    pin_oe[i] <= 1'b0;
                end else if (open_drain[i]) begin
                    // Open-drain only pulls low; a high level relies on the external pull-up.
                    pin_out[i] <= 1'b0;
                    pin_oe[i] <= out_en[i] && !drive_level;
                end else begin
                    pin_out[i] <= drive_level;
                    pin_oe[i] <= out_en[i];
                end
            end
        end
    endgenerate
endmodule : gpio_cfg_device
`default_nettype wire

// [dv/gpio_link_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module gpio_link_monitor (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic mosi,
    input wire logic miso
);
    // Frame length in reference cycles for the default half period of eight.
    localparam int FRAME_LOW = 272;
    logic [8:0] low_cnt;
    logic [4:0] fall_cnt;
    logic [15:0] rx_word;
    logic readback_due;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Counts cycles and falling clock edges inside a frame.
    always_ff @(posedge ref_clk) begin
        if (reset || sync_n) begin
            low_cnt <= 9'h000;
            fall_cnt <= 5'h00;
        end else begin
            low_cnt <= low_cnt + 9'h001;
            if ($fell(sclk)) begin
                fall_cnt <= fall_cnt + 5'h01;
            end
        end
    end

    // Rebuilds each frame so that the following frame can be judged as a readback.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_word <= 16'h0000;
            readback_due <= 1'b0;
        end else begin
            if (!sync_n && $fell(sclk)) begin
                rx_word <= {rx_word[14:0], mosi};
            end
            if ($rose(sync_n)) begin
                readback_due <= (rx_word[14:11] == 4'ha) && rx_word[10];
            end
        end
    end

    sequence s_lead_in;
        sclk [*8] ##1 sclk [*8] ##1 !sclk;
    endsequence
    sequence s_low_half;
        !sclk [*8] ##1 sclk;
    endsequence
    sequence s_gap;
        sync_n [*8];
    endsequence

    property p_top_bit_zero;
        $fell(sync_n) |-> !mosi;
    endproperty
    property p_lead_in;
        $fell(sync_n) |-> s_lead_in;
    endproperty
    property p_low_half;
        (!sync_n && $fell(sclk)) |-> s_low_half;
    endproperty
    property p_idle_clock;
        sync_n |-> sclk;
    endproperty
    property p_mosi_steady;
        (!sync_n && !sclk) |-> $stable(mosi);
    endproperty
    property p_frame_length;
        $rose(sync_n) |-> low_cnt == FRAME_LOW;
    endproperty
    property p_sixteen_bits;
        $rose(sync_n) |-> fall_cnt == 5'h10;
    endproperty
    property p_gap;
        $rose(sync_n) |-> s_gap;
    endproperty
    property p_readback_top_zero;
        (readback_due && !sync_n && !sclk && fall_cnt < 5'h08) |-> !miso;
    endproperty

    a_top_bit_zero: assert property (p_top_bit_zero)
        else $error("frame top bit was one");
    a_lead_in: assert property (p_lead_in)
        else $error("clock lead-in wrong");
    a_low_half: assert property (p_low_half)
        else $error("clock low half wrong");
    a_idle_clock: assert property (p_idle_clock)
        else $error("clock not idle high");
    a_mosi_steady: assert property (p_mosi_steady)
        else $error("data moved while clock low");
    a_frame_length: assert property (p_frame_length)
        else $error("frame length wrong");
    a_sixteen_bits: assert property (p_sixteen_bits)
        else $error("frame bit count wrong");
    a_gap: assert property (p_gap)
        else $error("gap between frames too short");
    a_readback_top_zero: assert property (p_readback_top_zero)
        else $error("readback upper byte not zero");
endmodule : gpio_link_monitor
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk;
    logic reset;
    logic [7:0] pin_in, pin_out, pin_oe;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    spi_link_if link_if();

    gpio_cfg_host gpio_cfg_host_inst (.ref_clk, .reset, .link(link_if),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    gpio_cfg_device gpio_cfg_device_inst (.ref_clk, .reset, .link(link_if),
        .pin_in, .pin_out, .pin_oe);
    gpio_link_monitor gpio_link_monitor_inst (.ref_clk, .reset, .sclk(link_if.sclk),
        .sync_n(link_if.sync_n), .mosi(link_if.mosi), .miso(link_if.miso));

    // Reference clock at 40 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Watchdog: about thirty frames need under ten thousand cycles, so this cuts a hang.
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors = num_errors + 1;
        end
    endtask : chk

    // Address and data are offered together; each is dropped at its own take.
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                chk(32'(s_axi_bresp), 32'(er));
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                rr = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_read

    // Polls status; the pins have settled well before the controller goes idle.
    task automatic wait_idle();
        rd = 32'h1;
        while (rd[0] === 1'b1) axi_read(gpio_cfg_pkg::STATUS_OFFSET);
        chk(32'(rd[0]), 32'h0);
    endtask : wait_idle

    task automatic send(input logic [15:0] f);
        axi_write(gpio_cfg_pkg::CMD_OFFSET, {16'h0000, f}, gpio_cfg_pkg::RESP_OKAY);
        wait_idle();
    endtask : send

    task automatic t_outputs();
        chk(32'(pin_oe), 32'h0);
        send(16'h40ff);
        send(16'h48a5);
        chk(32'(pin_oe), 32'hff);
        chk(32'(pin_out), 32'ha5);
        send(16'h485a);
        chk(32'(pin_out), 32'h5a);
        send(16'h400f);
        send(16'h48ff);
        chk(32'(pin_oe), 32'h0f);
        send(16'h40ff);
        chk(32'(pin_out), 32'h5f);
    endtask : t_outputs

    // Pins 4 to 7 are open-drain but not outputs, so they must stay undriven.
    task automatic t_open_drain();
        send(16'h400f);
        send(16'h60f3);
        send(16'h4802);
        chk(32'(pin_oe), 32'h0d);
        chk(32'(pin_out & pin_oe), 32'h0);
        send(16'h6000);
        chk(32'(pin_oe), 32'h0f);
    endtask : t_open_drain

    // A second command during a frame is refused and pin seven shows busy.
    task automatic t_busy();
        send(16'h4180);
        send(16'h4800);
        chk(32'({pin_oe[7], pin_out[7]}), 32'h3);
        axi_write(gpio_cfg_pkg::CMD_OFFSET, 32'h4880, gpio_cfg_pkg::RESP_OKAY);
        repeat (100) @(posedge ref_clk);
        chk(32'(pin_out[7]), 32'h0);
        axi_write(gpio_cfg_pkg::CMD_OFFSET, 32'h48ff, gpio_cfg_pkg::RESP_OKAY);
        wait_idle();
        axi_read(gpio_cfg_pkg::CMD_OFFSET);
        chk(rd, 32'h4880);
        send(16'h4000);
    endtask : t_busy

    task automatic t_readback(input logic [15:0] sel, input logic [15:0] req,
                              input logic [31:0] exp);
        send(sel);
        send(req);
        send(sel);
        axi_read(gpio_cfg_pkg::RX_OFFSET);
        chk(rd, exp);
    endtask : t_readback

    task automatic t_host_side();
        send(16'hc0ff);
        axi_read(gpio_cfg_pkg::CMD_OFFSET);
        chk(rd, 32'h40ff);
        send(16'h67ff);
        axi_read(gpio_cfg_pkg::CMD_OFFSET);
        chk(rd, 32'h60ff);
        send(16'h68f0);
        chk(32'(pin_oe), 32'h2d);
        axi_read(4'hc);
        chk(rd, 32'h0);
        chk(32'(rr), 32'(gpio_cfg_pkg::RESP_SLVERR));
        axi_write(4'hc, 32'h0, gpio_cfg_pkg::RESP_SLVERR);
        axi_write(gpio_cfg_pkg::STATUS_OFFSET, 32'h0, gpio_cfg_pkg::RESP_OKAY);
    endtask : t_host_side

    // Main sequence: inputs settle at time zero, reset for five cycles.
    initial begin
        reset = 1'b1;
        pin_in = 8'hb6;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wdata = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_outputs();
        t_open_drain();
        t_busy();
        t_readback(16'h50f0, 16'h5430, 32'h30);
        t_readback(16'h50f0, 16'h54ff, 32'hb0);
        t_readback(16'h5000, 16'h54ff, 32'h0);
        @(posedge ref_clk);
        pin_in <= 8'h49;
        t_readback(16'h500f, 16'h540f, 32'h09);
        t_host_side();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
